// ---- logic/tkr_regs.v ----
// touch key result readout, pin drive, restart marker, idle period,
// long-press release and option registers for eight sense channels
// assumes one clock, sync reset, host port with one-cycle read/write strobes
// and raw per-channel touch/reverse detections from the sensing front end
//
// Notes on behaviour
// (R1) each channel reports 2'b00 when not touched and 2'b11 when touched, never 01 or 10.
// (R2) offset 0x0b reads channels 7..4 in bit pairs 7:6 down to 1:0, all 00 after reset.
// (R3) a held channel drives its pin from its drive bit, low for 0 and high for 1, bits reset to 0.
// (R4) a sensing channel ignores its drive bit and leaves its pin undriven.
// (R5) bit 0 at offset 0x0d sets the spare output pin level, reset 0x01 so the pin starts high.
// (R6) the restart marker keeps any written byte and returns to 0x00 on every reset.
// (R7) idle mode checks for touch once every 100ms plus 100ms per step, step reset 2.
// (R8) a key touched longer than one second per limit step is forced released and re-initialised, limit reset 0x0c.
// (R9) option bit 0 enables the long-touch forced release and resets to 1.
// (R10) option bit 1, reset 0, re-initialises a key reverse-touched for more than 200ms, without forcing it released.
// (R11) option bit 2 selects single-key reporting at 0 and multi-key reporting at 1.
// (R12) option bit 3 picks the baseline tracking interval, 1 second at 0 and 200ms at 1, reset 1.
// (R13) with several keys in single-key mode, option bit 4 at 0 reports one of them and at 1 reports none.
// (R14) the option register resets to 0x09 with bits 7:5 reserved.
// (R15) a set hold bit stops sensing on that channel, clearing it resumes, all reset to 0.
// (R16) reserved bits read as zero and writes to them change nothing.
`timescale 1ns/100ps
`include "tkr_defs.vh"

module tkr_regs #(
  parameter CH       = 8,
  parameter MS_COUNT = `TKR_MS_CYCLES
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst,
  // host register port
  input  wire [7:0]    reg_addr,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire [7:0]    reg_wdata,
  output reg  [7:0]    reg_rdata,
  // sensing front end
  input  wire [CH-1:0] raw_touch,
  input  wire [CH-1:0] raw_reverse,
  input  wire          idle_mode,
  // sensing control
  output reg  [CH-1:0] channel_sense_hold,
  output reg  [CH-1:0] chan_reinit,
  output reg           idle_check,
  output reg           track_tick,
  output reg  [CH-1:0] key_touched,
  // pins
  output reg  [CH-1:0] chan_pin_o,
  output reg  [CH-1:0] chan_pin_oe,
  output reg           spare_output_pin
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0]  channel_pin_drive;
  reg        spare_pin_drive;
  reg [7:0]  restart_marker;
  reg [2:0]  idle_scan_period;
  reg [7:0]  long_press_limit;
  reg [4:0]  function_options;

  // full-byte reset images, cut to the implemented field widths below
  localparam [7:0] RST_SPARE   = `TKR_RST_SPARE;
  localparam [7:0] RST_IDLE    = `TKR_RST_IDLE;
  localparam [7:0] RST_OPTIONS = `TKR_RST_OPTIONS;

  wire long_touch_release_en    = function_options[`TKR_OPT_LONG_REL];
  wire reverse_touch_release_en = function_options[`TKR_OPT_REV_REL];
  wire many_key_report_sel      = function_options[`TKR_OPT_MANY_KEY];
  wire baseline_track_speed     = function_options[`TKR_OPT_TRACK];
  wire simultaneous_key_as_noise = function_options[`TKR_OPT_NOISE];

  always @(posedge clk_sys) begin
    if (rst) begin
      channel_sense_hold <= `TKR_RST_HOLD;                      // (R15)
      channel_pin_drive  <= `TKR_RST_PIN_DRIVE;                 // (R3)
      spare_pin_drive    <= RST_SPARE[0];                       // (R5)
      restart_marker     <= `TKR_RST_RESTART;                   // (R6)
      idle_scan_period   <= RST_IDLE[2:0];                      // (R7)
      long_press_limit   <= `TKR_RST_LIMIT;                     // (R8)
      function_options   <= RST_OPTIONS[4:0];                   // (R14)
    end else if (reg_wr) begin
      case (reg_addr)
        `TKR_OFS_HOLD:      channel_sense_hold <= reg_wdata;    // (R15)
        `TKR_OFS_PIN_DRIVE: channel_pin_drive  <= reg_wdata;    // (R3)
        `TKR_OFS_SPARE:     spare_pin_drive    <= reg_wdata[0]; // (R16)
        `TKR_OFS_RESTART:   restart_marker     <= reg_wdata;    // (R6)
        `TKR_OFS_IDLE:      idle_scan_period   <= reg_wdata[2:0];
        `TKR_OFS_LIMIT:     long_press_limit   <= reg_wdata;
        `TKR_OFS_OPTIONS:   function_options   <= reg_wdata[4:0]; // (R16)
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // millisecond tick shared by all timers
  // ----------------------------------------------------------------
  reg [31:0] ms_cnt;
  reg        ms_tick;
  always @(posedge clk_sys) begin
    if (rst) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b0;
    end else if (ms_cnt == MS_COUNT - 1) begin
      ms_cnt  <= 32'h0;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt  <= ms_cnt + 32'h1;
      ms_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // idle check period and baseline tracking tick
  // ----------------------------------------------------------------
  reg [9:0] idle_ms;
  reg [9:0] track_ms;
  wire [9:0] idle_len  = 10'd`TKR_IDLE_STEP_MS * ({7'h0, idle_scan_period} + 10'h1);  // (R7)
  wire [9:0] track_len = baseline_track_speed ? 10'd`TKR_TRACK_FAST_MS
                                              : 10'd`TKR_TRACK_SLOW_MS;            // (R12)
  always @(posedge clk_sys) begin
    if (rst) begin
      idle_ms    <= 10'h0;
      track_ms   <= 10'h0;
      idle_check <= 1'b0;
      track_tick <= 1'b0;
    end else begin
      idle_check <= 1'b0;
      track_tick <= 1'b0;
      if (!idle_mode) begin
        idle_ms <= 10'h0;
      end else if (ms_tick) begin
        if (idle_ms + 10'h1 >= idle_len) begin
          idle_ms    <= 10'h0;
          idle_check <= 1'b1;                                    // (R7)
        end else begin
          idle_ms <= idle_ms + 10'h1;
        end
      end
      if (ms_tick) begin
        if (track_ms + 10'h1 >= track_len) begin
          track_ms   <= 10'h0;
          track_tick <= 1'b1;                                    // (R12)
        end else begin
          track_ms <= track_ms + 10'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel long press and reverse touch timers
  // ----------------------------------------------------------------
  // press time kept in ms; limit of 255 s needs 18 bits
  reg [17:0] press_ms [0:CH-1];
  reg [7:0]  rev_ms   [0:CH-1];
  reg [CH-1:0] forced_off;
  wire [17:0] press_len = {10'h0, long_press_limit} * 18'd`TKR_HOLD_STEP_MS;  // (R8)
  wire [CH-1:0] sensed  = raw_touch & ~channel_sense_hold & ~forced_off;   // (R15)

  integer i;
  always @(posedge clk_sys) begin
    if (rst) begin
      for (i = 0; i < CH; i = i + 1) begin
        press_ms[i] <= 18'h0;
        rev_ms[i]   <= 8'h0;
      end
      forced_off  <= {CH{1'b0}};
      chan_reinit <= {CH{1'b0}};
    end else begin
      for (i = 0; i < CH; i = i + 1) begin
        chan_reinit[i] <= 1'b0;
        if (!raw_touch[i] || channel_sense_hold[i]) begin
          press_ms[i]   <= 18'h0;
          forced_off[i] <= 1'b0;
        end else if (ms_tick && !forced_off[i]) begin
          if (long_touch_release_en && press_ms[i] >= press_len) begin  // (R9)
            forced_off[i]  <= 1'b1;                                     // (R8)
            chan_reinit[i] <= 1'b1;
          end else if (press_ms[i] != 18'h3ffff) begin
            press_ms[i] <= press_ms[i] + 18'h1;
          end
        end
        if (!raw_reverse[i] || channel_sense_hold[i]) begin
          rev_ms[i] <= 8'h0;
        end else if (ms_tick) begin
          if (reverse_touch_release_en && rev_ms[i] >= `TKR_REV_MS) begin  // (R10)
            rev_ms[i]      <= 8'h0;
            chan_reinit[i] <= 1'b1;
          end else if (rev_ms[i] != 8'hff) begin
            rev_ms[i] <= rev_ms[i] + 8'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // key reporting
  // ----------------------------------------------------------------
  function [CH-1:0] lowest_bit;
    input [CH-1:0] v;
    begin
      lowest_bit = v & (~v + {{(CH-1){1'b0}}, 1'b1});
    end
  endfunction

  function [1:0] touch_code;
    input t;
    begin
      touch_code = t ? `TKR_CODE_ON : `TKR_CODE_OFF;    // (R1)
    end
  endfunction

  reg [CH-1:0] next_keys;
  always @* begin
    if (many_key_report_sel)                            // (R11)
      next_keys = sensed;
    else if (sensed != lowest_bit(sensed) && simultaneous_key_as_noise)
      next_keys = {CH{1'b0}};                           // (R13)
    else
      next_keys = lowest_bit(sensed);                   // (R13)
  end

  always @(posedge clk_sys) begin
    if (rst)
      key_touched <= {CH{1'b0}};
    else
      key_touched <= next_keys;
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      chan_pin_o       <= {CH{1'b0}};
      chan_pin_oe      <= {CH{1'b0}};
      spare_output_pin <= RST_SPARE[0];
    end else begin
      chan_pin_o       <= channel_pin_drive & channel_sense_hold;  // (R4)
      chan_pin_oe      <= channel_sense_hold;                      // (R3)
      spare_output_pin <= spare_pin_drive;                         // (R5)
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    case (reg_addr)
      `TKR_OFS_HOLD:      next_rdata = channel_sense_hold;
      `TKR_OFS_RESULT:    next_rdata = {touch_code(key_touched[7]), touch_code(key_touched[6]),
                                        touch_code(key_touched[5]), touch_code(key_touched[4])}; // (R2)
      `TKR_OFS_PIN_DRIVE: next_rdata = channel_pin_drive;
      `TKR_OFS_SPARE:     next_rdata = {7'h0, spare_pin_drive};   // (R16)
      `TKR_OFS_RESTART:   next_rdata = restart_marker;
      `TKR_OFS_IDLE:      next_rdata = {5'h0, idle_scan_period};
      `TKR_OFS_LIMIT:     next_rdata = long_press_limit;
      `TKR_OFS_OPTIONS:   next_rdata = {3'h0, function_options};  // (R16)
      default:            next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule

// ---- logic/tkr_defs.vh ----
// constants for the touch key result and option register bank
// assumes an 8-bit register port with byte offsets as used by the host interface
`ifndef TKR_DEFS_VH
`define TKR_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TKR_OFS_HOLD       8'h09
`define TKR_OFS_RESULT     8'h0b
`define TKR_OFS_PIN_DRIVE  8'h0c
`define TKR_OFS_SPARE      8'h0d
`define TKR_OFS_RESTART    8'h0e
`define TKR_OFS_IDLE       8'h1d
`define TKR_OFS_LIMIT      8'h1e
`define TKR_OFS_OPTIONS    8'h1f

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TKR_RST_HOLD       8'h00
`define TKR_RST_PIN_DRIVE  8'h00
`define TKR_RST_SPARE      8'h01
`define TKR_RST_RESTART    8'h00
`define TKR_RST_IDLE       8'h02
`define TKR_RST_LIMIT      8'h0c
`define TKR_RST_OPTIONS    8'h09

// ----------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------
`define TKR_OPT_LONG_REL   0
`define TKR_OPT_REV_REL    1
`define TKR_OPT_MANY_KEY   2
`define TKR_OPT_TRACK      3
`define TKR_OPT_NOISE      4
`define TKR_OPT_MASK       8'h1f
`define TKR_IDLE_MASK      8'h07
`define TKR_SPARE_MASK     8'h01
`define TKR_CODE_OFF       2'h0
`define TKR_CODE_ON        2'h3

// ----------------------------------------------------------------
// timing, in ms and in 125 MHz cycles
// ----------------------------------------------------------------
`define TKR_CLK_KHZ        125000
`define TKR_MS_CYCLES      (`TKR_CLK_KHZ)
`define TKR_IDLE_STEP_MS   100
`define TKR_HOLD_STEP_MS   1000
`define TKR_REV_MS         200
`define TKR_TRACK_SLOW_MS  1000
`define TKR_TRACK_FAST_MS  200

`endif

// ---- dv/tkr_regs_properties.sv ----
// port checker for the touch key register bank
// assumes one clock with synchronous active-high reset
`timescale 1ns/100ps
module tkr_regs_properties #(
  parameter CH       = 8,
  parameter MS_COUNT = 10
) (
  input wire          clk_sys,
  input wire          rst,
  input wire [7:0]    reg_addr,
  input wire          reg_wr,
  input wire          reg_rd,
  input wire [7:0]    reg_wdata,
  input wire [7:0]    reg_rdata,
  input wire [CH-1:0] raw_touch,
  input wire          idle_mode,
  input wire          idle_check,
  input wire          track_tick,
  input wire [CH-1:0] key_touched,
  input wire [CH-1:0] chan_pin_o,
  input wire [CH-1:0] chan_pin_oe,
  input wire          spare_output_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_PIN_SENSE: assert property ((chan_pin_o & ~chan_pin_oe) == 0)
    else $error("pin driven on a sensing channel");
  AST_KEY_CAUSE: assert property (!$past(rst) |-> (key_touched & ~$past(raw_touch)) == 0)
    else $error("key reported without touch");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_RD_RESULT: assert property (reg_rd && !reg_wr && reg_addr == 8'h0b |=>
    reg_rdata == {{2{$past(key_touched[7])}}, {2{$past(key_touched[6])}},
                  {2{$past(key_touched[5])}}, {2{$past(key_touched[4])}}})
    else $error("result read mismatch");
  AST_RD_UNMAPPED: assert property (reg_rd && !reg_wr && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_SPARE_WR: assert property (reg_wr && reg_addr == 8'h0d |-> ##2 spare_output_pin == $past(reg_wdata[0], 2))
    else $error("spare pin did not follow write");
  AST_IDLE_GATED: assert property (!$past(idle_mode) |-> !idle_check)
    else $error("idle check outside idle mode");
  AST_IDLE_PULSE: assert property (idle_check |=> !idle_check [*8])
    else $error("idle check too frequent");
  AST_TRACK_PULSE: assert property ($rose(track_tick) |=> !track_tick [*8])
    else $error("tracking tick too frequent");
endmodule
bind tkr_regs tkr_regs_properties #(.CH(CH), .MS_COUNT(MS_COUNT)) tkr_regs_properties_i (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .raw_touch(raw_touch), .idle_mode(idle_mode),
  .idle_check(idle_check), .track_tick(track_tick), .key_touched(key_touched),
  .chan_pin_o(chan_pin_o), .chan_pin_oe(chan_pin_oe), .spare_output_pin(spare_output_pin));

// ---- dv/tkr_front_model.sv ----
// sensing front end stand-in
// assumes bench requests, passed on just after each clock edge
`timescale 1ns/100ps
module tkr_front_model (
  // clock and requests
  input  wire       clk_sys,
  input  wire [7:0] touch_req,
  input  wire [7:0] rev_req,
  input  wire       idle_req,
  // detections toward the bank
  output reg  [7:0] raw_touch   = 8'h00,
  output reg  [7:0] raw_reverse = 8'h00,
  output reg        idle_mode   = 1'b0
);
  // requests are taken on the edge by non-blocking update, one cycle of latency,
  // so the bench's own post-edge drive never races with this model
  always @(posedge clk_sys) begin
    raw_touch   <= touch_req;
    raw_reverse <= rev_req;
    idle_mode   <= idle_req;
  end
endmodule

// ---- dv/tkr_regs_tb_top.sv ----
// self-checking bench for the touch key register bank
// assumes the front-end model and checker are compiled first
`timescale 1ns/100ps
module tkr_regs_tb_top;
  localparam MS = 10;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, idle_req = 0, idle_mode, idle_check, track_tick, spare;
  logic [7:0] reg_addr = 0, reg_wdata = 0, touch_req = 0, rev_req = 0, reg_rdata, got;
  logic [7:0] raw_touch, raw_reverse, hold, reinit, keys, pin_o, pin_oe, mem [0:31];
  logic [7:0] ad [0:8] = '{8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h1d, 8'h1e, 8'h1f, 8'h10};
  logic [7:0] opts [0:2] = '{8'h00, 8'h04, 8'h10};
  logic [7:0] pats [0:2] = '{8'hb0, 8'h40, 8'h00};
  integer err_count = 0, checked = 0, seed = 32'h148329f7, i, t, n;
  tkr_regs #(.MS_COUNT(MS)) tkr_regs_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .raw_touch(raw_touch), .raw_reverse(raw_reverse), .idle_mode(idle_mode),
    .channel_sense_hold(hold), .chan_reinit(reinit), .idle_check(idle_check), .track_tick(track_tick),
    .key_touched(keys), .chan_pin_o(pin_o), .chan_pin_oe(pin_oe), .spare_output_pin(spare));
  tkr_front_model tkr_front_model_i (.clk_sys(clk_sys), .touch_req(touch_req), .rev_req(rev_req),
    .idle_req(idle_req), .raw_touch(raw_touch), .raw_reverse(raw_reverse), .idle_mode(idle_mode));
  always #4 clk_sys = ~clk_sys;
  task final_report;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // writable bits per offset; zero marks read-only or unmapped places
  function logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h09, 8'h0c, 8'h0e, 8'h1e: msk = 8'hff;
      8'h0d: msk = 8'h01;
      8'h1d: msk = 8'h07;
      8'h1f: msk = 8'h1f;
      default: msk = 8'h00;
    endcase
  endfunction
  function logic [7:0] exp_keys(input logic [7:0] tch);
    logic [7:0] v;
    v = tch & ~mem[9];
    if (!mem[31][2] && $countones(v) > 1)
      v = mem[31][4] ? 8'h00 : v & -v;
    return v;
  endfunction
  function logic [7:0] exp_res(input logic [7:0] k);
    return {{2{k[7]}}, {2{k[6]}}, {2{k[5]}}, {2{k[4]}}};
  endfunction
  task do_reset;
    rst = 1;
    tick(12);
    foreach (mem[j]) mem[j] = 8'h00;
    mem[13] = 8'h01;
    mem[29] = 8'h02;
    mem[30] = 8'h0c;
    mem[31] = 8'h09;
    rst = 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    mem[a[4:0]] = d & msk(a);
    tick(1);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    cmp(reg_rdata, e);
    tick(1);
  endtask
  // sel 0 idle check, 1 tracking tick, 2 any re-init; c counts cycles waited
  task wait_ev(input integer sel, input integer lim, output integer c);
    c = 0;
    while (!(sel == 0 ? idle_check : sel == 1 ? track_tick : |reinit)) begin
      c++;
      if (c > lim) begin
        err_count++;
        $display("CHECK FAILED %0t timeout", $time);
        final_report;
      end
      tick(1);
    end
    got = reinit;
    tick(1);
  endtask
  initial begin
    do_reset;
    cmp(spare, 1'b1);
    cmp(pin_oe, 8'h00);
    for (i = 0; i < 9; i++) rdc(ad[i], mem[ad[i][4:0]]);
    repeat (3) begin
      for (i = 0; i < 9; i++) wr(ad[i], $random(seed));
      for (i = 0; i < 9; i++) rdc(ad[i], i == 1 ? 8'h00 : mem[ad[i][4:0]]);
      cmp(pin_oe, mem[9]);
      cmp(hold, mem[9]);
      cmp(pin_o, mem[9] & mem[12]);
      cmp(spare, mem[13][0]);
    end
    wr(8'h09, 8'h80);
    for (i = 0; i < 3; i++) begin
      wr(8'h1f, opts[i]);
      for (t = 0; t < 3; t++) begin
        touch_req = pats[t];
        tick(3);
        cmp(keys, exp_keys(touch_req));
        rdc(8'h0b, exp_res(exp_keys(touch_req)));
      end
    end
    idle_req = 1;
    wr(8'h1d, 8'h01);
    wait_ev(0, 3000 * MS, n);
    wait_ev(0, 3000 * MS, n);
    cmp(n + 1, 200 * MS);
    idle_req = 0;
    for (i = 0; i < 2; i++) begin
      wr(8'h1f, i ? 8'h01 : 8'h08);
      wait_ev(1, 3000 * MS, n);
      wait_ev(1, 3000 * MS, n);
      cmp(n + 1, (i ? 1000 : 200) * MS);
    end
    wr(8'h1e, 8'h01);
    touch_req = 8'h01;
    wait_ev(2, 1003 * MS, n);
    cmp(got, 8'h01);
    cmp(n >= 999 * MS, 1);
    touch_req = 0;
    tick(3);
    wr(8'h1f, 8'h00);
    touch_req = 8'h01;
    n = 0;
    repeat (1100 * MS) begin
      tick(1);
      n += |reinit;
    end
    cmp(n, 0);
    touch_req = 0;
    wr(8'h1f, 8'h02);
    rev_req = 8'h02;
    wait_ev(2, 203 * MS, n);
    cmp(got, 8'h02);
    cmp(n >= 199 * MS, 1);
    rev_req = 0;
    wr(8'h0e, 8'h5a);
    rdc(8'h0e, 8'h5a);
    do_reset;
    rdc(8'h0e, 8'h00);
    final_report;
  end
endmodule
